// >>> rtl/clk_sleep_ctrl.v
// Purpose: PLL, rate select and sleep/wake control
// Assumes: one clock, synchronous reset, single-cycle register port
// Notes: rate outputs are multiplier exponents, not clocks
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`include "clk_sleep_defines.vh"
module clk_sleep_ctrl
(
	// Clock and reset
	input wire clock,
	input wire rst,
	// Register port
	input wire [15:0] addr,
	input wire [7:0] wdata,
	input wire wr,
	input wire rd,
	output reg [7:0] rdata,
	// Analog status
	input wire pll_lock_in,
	input wire xtal_stopped,
	input wire comparator_b_output,
	// Wake sources
	input wire io_rtc_wake,
	input wire energy_pulse_output,
	input wire power_recovery,
	input wire deep_wake,
	// Controls out
	output wire pll_power_enable,
	output wire bandgap_power_enable,
	output wire [1:0] adc_rate_select,
	output wire [1:0] metering_rate_select,
	output reg [3:0] cpu_rate_exp,
	output wire main_clock_from_pll,
	output wire main_clock_run,
	output wire [1:0] system_state,
	output reg wake_reset
);
	// Clock control register and its next value
	reg [7:0] clk_ctrl_r;
	reg [7:0] clk_ctrl_nxt;
	// CPU doubler pair
	reg [1:0] pll_dbl_r;
	reg [1:0] pll_dbl_nxt;
	// Power-up hold bit
	reg hold_r;
	reg hold_nxt;
	// Wake-without-reset bit
	reg wake_nr_r;
	reg wake_nr_nxt;
	// Sleep selects and system-control flags
	reg [3:0] sys_ctrl_r;
	reg [3:0] sys_ctrl_nxt;
	// Main clock source and run bits
	reg src_pll_r;
	reg src_pll_nxt;
	reg clk_on_r;
	reg clk_on_nxt;
	// System state
	reg [1:0] state_r;
	reg [1:0] state_nxt;
	// Read path and wake pulse
	reg [7:0] rdata_nxt;
	reg wake_reset_nxt;
	// Wake qualifiers, masked lock and PLL enable
	reg wake;
	wire soft_reset;
	wire lock;
	wire pll_en;
	// Address hits
	wire hit_lock;
	wire hit_clk_ctrl;
	wire hit_pll_ctrl;
	wire hit_ana_state;
	wire hit_sys_state;
	wire hit_io_wake;
	wire hit_sys_ctrl;
	wire hit_clk_src;
	// Write enables
	wire wr_ok;
	wire wr_clk_ctrl;
	wire wr_pll_ctrl;
	wire wr_sys_state;
	wire wr_io_wake;
	wire wr_sys_ctrl;
	wire wr_clk_src;
	// State conditions
	wire go_work;
	wire go_sleep;
	wire leave_work;
	wire light_wake_ev;
	wire deep_wake_ev;

	assign hit_lock = (addr == `ADDR_PLL_LOCK);
	assign hit_clk_ctrl = (addr == `ADDR_CLK_CTRL);
	assign hit_pll_ctrl = (addr == `ADDR_PLL_CTRL);
	assign hit_ana_state = (addr == `ADDR_ANA_STATE);
	assign hit_sys_state = (addr == `ADDR_SYS_STATE);
	assign hit_io_wake = (addr == `ADDR_IO_WAKE);
	assign hit_sys_ctrl = (addr == `ADDR_SYS_CTRL);
	assign hit_clk_src = (addr == `ADDR_CLK_SRC);

	// Writes in a wake cycle are dropped
	assign wr_ok = wr & ~wake;
	assign wr_clk_ctrl = wr_ok & hit_clk_ctrl;
	assign wr_pll_ctrl = wr_ok & hit_pll_ctrl;
	assign wr_sys_state = wr_ok & hit_sys_state;
	assign wr_io_wake = wr_ok & hit_io_wake;
	assign wr_sys_ctrl = wr_ok & hit_sys_ctrl;
	assign wr_clk_src = wr_ok & hit_clk_src;

	// Wake with reset reloads every reset value except rdata and wake_reset
	assign soft_reset = wake & ~wake_nr_r;

	assign pll_en = clk_ctrl_r[`BIT_PLL_EN];
	assign pll_power_enable = pll_en;
	assign bandgap_power_enable = clk_ctrl_r[`BIT_BG_EN];
	assign adc_rate_select = clk_ctrl_r[`FLD_ADC_HI:`FLD_ADC_LO];
	assign metering_rate_select = clk_ctrl_r[`FLD_MTR_HI:`FLD_MTR_LO];
	// Lock is masked while the PLL is off
	assign lock = pll_lock_in & pll_en;
	assign main_clock_from_pll = src_pll_r;
	assign main_clock_run = clk_on_r;
	assign system_state = state_r;

	assign go_work = src_pll_r & pll_en & clk_on_r;
	assign go_sleep = ~hold_r & ~src_pll_r & ~clk_on_r;
	assign leave_work = ~src_pll_r | ~pll_en;
	assign light_wake_ev = io_rtc_wake | energy_pulse_output | power_recovery;
	assign deep_wake_ev = deep_wake | power_recovery;

	// CPU multiplier exponent plus doublers
	always @*
	begin
		cpu_rate_exp = {2'h0, clk_ctrl_r[`FLD_CPU_HI:`FLD_CPU_LO]};
		if (pll_dbl_r[0])
		begin
			cpu_rate_exp = cpu_rate_exp + 4'h1;
			if (pll_dbl_r[1])
			begin
				cpu_rate_exp = cpu_rate_exp + 4'h1;
			end
		end
	end

	// State transitions
	always @*
	begin
		state_nxt = state_r;
		wake = 1'b0;
		case (state_r)
			`ST_OSC:
			begin
				if (go_work)
				begin
					state_nxt = `ST_WORK;
				end
				else if (go_sleep)
				begin
					if (sys_ctrl_r[`SYS_SEL_DEEP])
						state_nxt = `ST_DEEP;
					else
						state_nxt = `ST_LIGHT;
				end
			end
			`ST_WORK:
			begin
				if (leave_work)
				begin
					state_nxt = `ST_OSC;
				end
			end
			`ST_LIGHT:
			begin
				wake = light_wake_ev;
			end
			`ST_DEEP:
			begin
				wake = deep_wake_ev;
			end
			default:
			begin
				state_nxt = `ST_OSC;
			end
		endcase
		if (wake)
		begin
			state_nxt = `ST_OSC;
		end
	end

	always @(posedge clock)
	begin
		if (rst | soft_reset)
			state_r <= `ST_OSC;
		else
			state_r <= state_nxt;
	end

	// Clock control register
	always @*
	begin
		clk_ctrl_nxt = clk_ctrl_r;
		if (wr_clk_ctrl)
		begin
			clk_ctrl_nxt = wdata;
		end
	end

	always @(posedge clock)
	begin
		if (rst | soft_reset)
			clk_ctrl_r <= `RST_CLK_CTRL;
		else
			clk_ctrl_r <= clk_ctrl_nxt;
	end

	// PLL control doublers
	always @*
	begin
		pll_dbl_nxt = pll_dbl_r;
		if (wr_pll_ctrl)
		begin
			pll_dbl_nxt = wdata[`BIT_DBL2:`BIT_DBL1];
		end
	end

	always @(posedge clock)
	begin
		if (rst | soft_reset)
			pll_dbl_r <= `RST_PLL_DBL;
		else
			pll_dbl_r <= pll_dbl_nxt;
	end

	// Power-up hold; cleared by software before sleep
	always @*
	begin
		hold_nxt = hold_r;
		if (wr_sys_state)
		begin
			hold_nxt = wdata[`BIT_HOLD];
		end
	end

	always @(posedge clock)
	begin
		if (rst | soft_reset)
			hold_r <= `RST_HOLD;
		else
			hold_r <= hold_nxt;
	end

	// Wake-without-reset select
	always @*
	begin
		wake_nr_nxt = wake_nr_r;
		if (wr_io_wake)
		begin
			wake_nr_nxt = wdata[`BIT_WAKE_NR];
		end
	end

	always @(posedge clock)
	begin
		if (rst | soft_reset)
			wake_nr_r <= `RST_WAKE_NR;
		else
			wake_nr_r <= wake_nr_nxt;
	end

	// Sleep selects and flags; any wake clears them
	always @*
	begin
		sys_ctrl_nxt = sys_ctrl_r;
		if (wake)
		begin
			sys_ctrl_nxt = 4'h0;
		end
		else if (wr_sys_ctrl)
		begin
			sys_ctrl_nxt = wdata[`FLD_SYS_HI:`FLD_SYS_LO];
		end
	end

	always @(posedge clock)
	begin
		if (rst | soft_reset)
			sys_ctrl_r <= `RST_SYS_CTRL;
		else
			sys_ctrl_r <= sys_ctrl_nxt;
	end

	// Main clock source select
	always @*
	begin
		src_pll_nxt = src_pll_r;
		if (wr_clk_src)
		begin
			src_pll_nxt = wdata[`BIT_SRC_PLL];
		end
	end

	always @(posedge clock)
	begin
		if (rst | soft_reset)
			src_pll_r <= `RST_SRC_PLL;
		else
			src_pll_r <= src_pll_nxt;
	end

	// Main clock run; a wake restarts it
	always @*
	begin
		clk_on_nxt = clk_on_r;
		if (wake)
		begin
			clk_on_nxt = 1'b1;
		end
		else if (wr_clk_src)
		begin
			clk_on_nxt = wdata[`BIT_CLK_RUN];
		end
	end

	always @(posedge clock)
	begin
		if (rst | soft_reset)
			clk_on_r <= `RST_CLK_RUN;
		else
			clk_on_r <= clk_on_nxt;
	end

	// One-cycle pulse after a wake with reset
	always @*
	begin
		wake_reset_nxt = soft_reset;
	end

	always @(posedge clock)
	begin
		if (rst)
			wake_reset <= 1'b0;
		else
			wake_reset <= wake_reset_nxt;
	end

	// Read mux; idle cycles return zero
	always @*
	begin
		rdata_nxt = 8'h00;
		if (rd)
		begin
			if (hit_lock)
				rdata_nxt = {7'h00, lock};
			else if (hit_clk_ctrl)
				rdata_nxt = clk_ctrl_r;
			else if (hit_pll_ctrl)
				rdata_nxt = {pll_dbl_r, 6'h00};
			else if (hit_ana_state)
				rdata_nxt = {xtal_stopped, 1'b0, comparator_b_output, `ANA_FIXED, 2'h0};
			else if (hit_sys_state)
				rdata_nxt = {7'h00, hold_r};
			else if (hit_io_wake)
				rdata_nxt = {7'h00, wake_nr_r};
			else if (hit_sys_ctrl)
				rdata_nxt = {sys_ctrl_r, 4'h0};
			else if (hit_clk_src)
				rdata_nxt = {6'h00, clk_on_r, src_pll_r};
			else
				rdata_nxt = 8'h00;
		end
	end

	// Read data one cycle after strobe
	always @(posedge clock)
	begin
		if (rst)
			rdata <= 8'h00;
		else
			rdata <= rdata_nxt;
	end
endmodule

// >>> rtl/clk_sleep_defines.vh
// Purpose: constants for the clock and sleep control block
// Assumes: 8-bit register port, byte addresses as printed
// Notes: field positions and reset values used by the design; the bench repeats them as literals
// Function
// - PLL lock flag is read-only bit 0; upper bits read zero.
// - Clock control bit 7 powers the PLL; reset 0.
// - Clock control bit 6 powers the bandgap; reset 0.
// - Bits 5:4 scale ADC sample clock 204.8 kHz by 1, 2, 4.
// - Bits 3:2 scale metering clock 819.2 kHz by 1, 2, 4.
// - Bits 1:0 scale CPU clock 819.2 kHz by 1, 2, 4, 8.
// - PLL control bit 6 doubles CPU clock; bit 7 doubles again with bit 6.
// - Analog state bit 7 is 1 when crystal stopped and RC clock feeds all.
// - Analog state bit 5 shows comparator B output.
// - Three system states: oscillator, working, sleeping.
// - Level 1 or 2 reset enters oscillator state on crystal clock.
// - Working state has PLL enabled driving main clock.
// - Clear hold bit, select oscillator, stop main clock: enter sleep.
// - Default wake applies reset and returns to oscillator state.
// - Wake-without-reset resumes; clears only sleep selects and two flags.
// - Sleep has light and deep sub-states chosen by sleep select bits.
// - Light sleep ends on IO/RTC wake, energy pulse or power recovery.
`ifndef CLK_SLEEP_DEFINES_VH
`define CLK_SLEEP_DEFINES_VH
`define ADDR_PLL_LOCK 16'h00A3
`define ADDR_SYS_STATE 16'h00A1
`define ADDR_IO_WAKE 16'h00C9
`define ADDR_SYS_CTRL 16'h0080
`define ADDR_CLK_CTRL 16'h2867
`define ADDR_PLL_CTRL 16'h2868
`define ADDR_ANA_STATE 16'h286B
`define ADDR_CLK_SRC 16'h2870
`define BIT_PLL_EN 7
`define BIT_BG_EN 6
`define BIT_DBL2 7
`define BIT_DBL1 6
`define BIT_XTAL_STOP 7
`define BIT_CMPB 5
`define BIT_HOLD 0
`define BIT_WAKE_NR 0
`define BIT_SRC_PLL 0
`define BIT_CLK_RUN 1
`define FLD_ADC_HI 5
`define FLD_ADC_LO 4
`define FLD_MTR_HI 3
`define FLD_MTR_LO 2
`define FLD_CPU_HI 1
`define FLD_CPU_LO 0
`define FLD_SYS_HI 7
`define FLD_SYS_LO 4
`define SYS_SEL_DEEP 3
`define RST_PLL_DBL 2'h0
`define RST_HOLD 1'b1
`define RST_WAKE_NR 1'b0
`define RST_SYS_CTRL 4'h0
`define RST_SRC_PLL 1'b0
`define RST_CLK_RUN 1'b1
`define BIT_SLP1 7
`define BIT_SLP0 6
`define BIT_FLAG_W 5
`define BIT_FLAG_S 4
`define ANA_FIXED 3'h5
`define RST_CLK_CTRL 8'h00
`define RST_PLL_CTRL 8'h00
`define ST_OSC 2'h0
`define ST_WORK 2'h1
`define ST_LIGHT 2'h2
`define ST_DEEP 2'h3
`endif

// >>> test/clk_sleep_props_properties.sv
// Purpose: port checker for clk_sleep_ctrl
// Assumes: one clock, sync active-high reset
// Notes: attached by bind below
`timescale 1ns/1ps
module clk_sleep_props
(
	// Single pins
	input logic clock, rst, wr, rd, pll_lock_in, xtal_stopped, comparator_b_output,
	input logic io_rtc_wake, energy_pulse_output, power_recovery, deep_wake,
	input logic pll_power_enable, bandgap_power_enable, main_clock_from_pll,
	input logic main_clock_run, wake_reset,
	// Buses
	input logic [15:0] addr,
	input logic [7:0] wdata, rdata,
	input logic [1:0] adc_rate_select, metering_rate_select, system_state
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	wire cw = wr && addr == 16'h2867 && !system_state[1];
	chk_lock_read: assert property (rd && addr == 16'h00A3 |=>
		rdata == {7'h00, $past(pll_lock_in & pll_power_enable)}) else $error("lock read");
	chk_power_bits: assert property (cw |=>
		{pll_power_enable, bandgap_power_enable} == $past(wdata[7:6])) else $error("power bits");
	chk_rate_fields: assert property (cw |=>
		{adc_rate_select, metering_rate_select} == $past(wdata[5:2])) else $error("rate fields");
	chk_analog_read: assert property (rd && addr == 16'h286B |=> rdata[4:2] == 3'h5 &&
		rdata[7] == $past(xtal_stopped) && rdata[5] == $past(comparator_b_output))
		else $error("analog read");
	chk_idle_rdata: assert property (!$past(rd) |-> rdata == 8'h00) else $error("rdata idle");
	chk_reset_osc: assert property (disable iff (1'b0) rst |=> system_state == 2'h0 &&
		main_clock_run && !pll_power_enable) else $error("reset state");
	chk_work_entry: assert property ($rose(system_state == 2'h1) |->
		$past(pll_power_enable) && $past(main_clock_from_pll)) else $error("work entry");
	chk_sleep_entry: assert property ($rose(system_state[1]) |->
		$past(!main_clock_run && !main_clock_from_pll)) else $error("sleep entry");
	chk_light_wake: assert property (system_state == 2'h2 && (io_rtc_wake ||
		energy_pulse_output || power_recovery) |=> system_state == 2'h0) else $error("light wake");
	chk_deep_hold: assert property (system_state == 2'h3 && !deep_wake &&
		!power_recovery |=> system_state == 2'h3) else $error("deep hold");
	chk_wake_pulse: assert property (wake_reset |=> !wake_reset) else $error("wake pulse");
endmodule
bind clk_sleep_ctrl clk_sleep_props props (.clock, .rst, .wr, .rd, .pll_lock_in, .xtal_stopped,
	.comparator_b_output, .io_rtc_wake, .energy_pulse_output, .power_recovery, .deep_wake,
	.pll_power_enable, .bandgap_power_enable, .main_clock_from_pll, .main_clock_run,
	.wake_reset, .addr, .wdata, .rdata, .adc_rate_select, .metering_rate_select, .system_state);

// >>> test/clk_sleep_ctrl_tb.sv
// Purpose: self-checking bench for clk_sleep_ctrl
// Assumes: 25 MHz clock, sync reset
// Notes: seed 8, random register data
`timescale 1ns/1ps
module clk_sleep_ctrl_tb;
reg clock = 0, rst = 1, wr = 0, rd = 0, pll_lock_in = 0, xtal_stopped = 0;
reg comparator_b_output = 0, io_rtc_wake = 0, energy_pulse_output = 0;
reg power_recovery = 0, deep_wake = 0;
reg [15:0] addr = 16'h0000;
reg [7:0] wdata = 8'h00, c, p;
reg [31:0] r;
wire [7:0] rdata;
wire pll_power_enable, bandgap_power_enable, main_clock_from_pll, main_clock_run, wake_reset;
wire [1:0] adc_rate_select, metering_rate_select, system_state;
wire [3:0] cpu_rate_exp;
integer err_count = 0, compares = 0, i, n;
clk_sleep_ctrl dut (.clock, .rst, .addr, .wdata, .wr, .rd, .rdata, .pll_lock_in,
	.xtal_stopped, .comparator_b_output, .io_rtc_wake, .energy_pulse_output,
	.power_recovery, .deep_wake, .pll_power_enable, .bandgap_power_enable,
	.adc_rate_select, .metering_rate_select, .cpu_rate_exp, .main_clock_from_pll,
	.main_clock_run, .system_state, .wake_reset);
initial forever #20 clock = ~clock;
function [3:0] cexp(input [7:0] cc, input [7:0] pc);
	cexp = cc[1:0] + pc[6] + (pc[7] & pc[6]);
endfunction
task end_of_test;
begin
	$display("compares %0d err_count %0d", compares, err_count);
	if (err_count == 0 && compares > 0)
		$display("NO MISMATCHES");
	else
		$display("MISMATCHES SEEN");
	$finish;
end
endtask
task chk(input [7:0] got, input [7:0] exp);
begin
	compares = compares + 1;
	if (got !== exp)
	begin
		err_count = err_count + 1;
		$display("BAD %0t got %h want %h", $time, got, exp);
	end
end
endtask
task wrt(input [15:0] a, input [7:0] d);
begin
	@(posedge clock);
	wr <= 1'b1;
	addr <= a;
	wdata <= d;
	@(posedge clock);
	wr <= 1'b0;
end
endtask
task rdc(input [15:0] a, input [7:0] e);
begin
	@(posedge clock);
	rd <= 1'b1;
	addr <= a;
	@(posedge clock);
	rd <= 1'b0;
	@(negedge clock);
	chk(rdata, e);
end
endtask
task wst(input [1:0] s);
begin
	i = 0;
	while (system_state !== s && i < 9)
	begin
		@(negedge clock);
		i = i + 1;
	end
	chk({6'h00, system_state}, {6'h00, s});
	if (system_state !== s)
		end_of_test;
end
endtask
initial
begin
	r = $urandom(8);
	repeat (4) @(posedge clock);
	rst <= 1'b0;
	rdc(16'h2867, 8'h00);
	rdc(16'h00A3, 8'h00);
	wst(2'h0);
	$display("reset test done");
	for (n = 0; n < 12; n = n + 1)
	begin
		r = $urandom;
		c = (n == 0) ? 8'hEB : r[7:0];
		p = (n == 0) ? 8'hC0 : r[15:8];
		c[4] = c[4] & ~c[5];
		c[2] = c[2] & ~c[3];
		c[6] = c[6] | c[7];
		@(posedge clock);
		{xtal_stopped, comparator_b_output, pll_lock_in} <= r[18:16];
		wrt(16'h2867, c);
		wrt(16'h2868, p);
		@(negedge clock);
		chk({pll_power_enable, bandgap_power_enable, adc_rate_select,
			metering_rate_select, 2'h0}, {c[7:2], 2'h0});
		chk({4'h0, cpu_rate_exp}, {4'h0, cexp(c, p)});
		rdc(16'h2867, c);
		rdc(16'h00A3, {7'h00, pll_lock_in & c[7]});
		rdc(16'h286B, {xtal_stopped, 1'b0, comparator_b_output, 5'h14});
	end
	wrt(16'h00A3, 8'hFF);
	rdc(16'h00A3, {7'h00, pll_lock_in & c[7]});
	rdc(16'h1234, 8'h00);
	$display("register test done");
	wrt(16'h2867, 8'hC0);
	@(posedge clock);
	pll_lock_in <= 1'b1;
	rdc(16'h00A3, 8'h01);
	wrt(16'h2870, 8'h03);
	wst(2'h1);
	wrt(16'h00A1, 8'h00);
	wrt(16'h2870, 8'h02);
	wst(2'h0);
	wrt(16'h2870, 8'h00);
	wst(2'h2);
	@(posedge clock);
	io_rtc_wake <= 1'b1;
	wst(2'h0);
	chk({7'h00, wake_reset}, 8'h01);
	chk({6'h00, main_clock_run, main_clock_from_pll}, 8'h02);
	@(posedge clock);
	io_rtc_wake <= 1'b0;
	rdc(16'h2867, 8'h00);
	wrt(16'h00C9, 8'h01);
	wrt(16'h0080, 8'hF0);
	wrt(16'h2867, 8'h4A);
	wrt(16'h00A1, 8'h00);
	wrt(16'h2870, 8'h00);
	wst(2'h3);
	@(posedge clock);
	io_rtc_wake <= 1'b1;
	repeat (3) @(negedge clock);
	chk({6'h00, system_state}, 8'h03);
	@(posedge clock);
	deep_wake <= 1'b1;
	wst(2'h0);
	chk({6'h00, main_clock_run, wake_reset}, 8'h02);
	@(posedge clock);
	deep_wake <= 1'b0;
	io_rtc_wake <= 1'b0;
	rdc(16'h2867, 8'h4A);
	rdc(16'h0080, 8'h00);
	$display("sleep test done");
	end_of_test;
end
endmodule
